// ### logic/clock_select_prescalers.sv
// clock source selection, prescalers and their register file
//
// Notes on behaviour
// - slow clock from oscillator if select set
// - fast select 1 uses main, 0 PLL
// - PLL switch ignored while power-down set
// - PLL switch ignored until PLL stable
// - power-down bit asserts PLL stop signal
// - power-down set ignored while PLL selected
// - power-down bit resets to one
// - aux clock 1 runs when enabled, main stable
// - aux clock 2 runs when enabled, main stable
// - POR flag set by hardware, cleared by zero
// - fast prescaler resets to 4f except programming
// - system clock is source over divisor plus one
// - mode field selects PLL multiplier, resets 100 except programming
// - slow clock is main over 2(div+1)
// - aux clock 1 is main over div1 plus one
// - aux clock 2 is main over div2 plus one
`timescale 1ns/100ps
module clock_select_prescalers
  import clk_ctrl_pkg::*;
#(
  parameter logic [7:0] PROGRAMMING_MODE_FAST_INIT = 8'h00
) (
  // clock and reset
  input  wire logic                  CLK_SYS,
  input  wire logic                  RST_N,
  // axi4-lite write address
  input  wire logic                  S_AXI_AWVALID,
  output logic                       S_AXI_AWREADY,
  input  wire logic [AXI_ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic [2:0]            S_AXI_AWPROT,
  // axi4-lite write data
  input  wire logic                  S_AXI_WVALID,
  output logic                       S_AXI_WREADY,
  input  wire logic [AXI_DATA_W-1:0] S_AXI_WDATA,
  input  wire logic [3:0]            S_AXI_WSTRB,
  // axi4-lite write response
  output logic                       S_AXI_BVALID,
  input  wire logic                  S_AXI_BREADY,
  output logic [1:0]                 S_AXI_BRESP,
  // axi4-lite read
  input  wire logic                  S_AXI_ARVALID,
  output logic                       S_AXI_ARREADY,
  input  wire logic [AXI_ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic [2:0]            S_AXI_ARPROT,
  output logic                       S_AXI_RVALID,
  input  wire logic                  S_AXI_RREADY,
  output logic [AXI_DATA_W-1:0]      S_AXI_RDATA,
  output logic [1:0]                 S_AXI_RRESP,
  // source ticks on this clock
  input  wire logic                  MAIN_TICK,
  input  wire logic                  PLL_TICK,
  // pins from outside the clock domain
  input  wire logic                  OSC32K_IN,
  input  wire logic                  MAIN_STABLE,
  input  wire logic                  PLL_STABLE,
  input  wire logic                  POWER_UP_DET,
  input  wire logic                  PMM_PLL_STOP,
  input  wire logic                  PROGRAMMING_MODE,
  // clock enables out
  output logic                       SYS_CLK_EN,
  output logic                       SLOW_CLK_EN,
  output logic                       AUX1_CLK_EN,
  output logic                       AUX2_CLK_EN,
  // pll control
  output logic                       PLL_STOP,
  output logic [2:0]                 PLL_MULT
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  localparam int NSYNC = 6;

  logic [NSYNC-1:0] pin_in;
  logic [NSYNC-1:0] pin_q1;
  logic [NSYNC-1:0] pin_q2;
  logic [NSYNC-1:0] pin_q3;
  logic [NSYNC-1:0] pin_lvl_r;

  assign pin_in = {PROGRAMMING_MODE, PMM_PLL_STOP, POWER_UP_DET,
                   PLL_STABLE, MAIN_STABLE, OSC32K_IN};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge CLK_SYS) begin
        pin_q1[gi] <= pin_in[gi];
        pin_q2[gi] <= pin_q1[gi];
        pin_q3[gi] <= pin_q2[gi];
      end

      // a change counts once the second and third stage agree
      always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
          pin_lvl_r[gi] <= 1'b0;
        end else if (pin_q2[gi] == pin_q3[gi]) begin
          pin_lvl_r[gi] <= pin_q3[gi];
        end
      end
    end
  endgenerate

  logic osc_lvl;
  logic main_ok;
  logic pll_ok;
  logic pwr_up;
  logic pmm_stop;
  logic programming_mode_q;

  assign osc_lvl  = pin_lvl_r[0];
  assign main_ok  = pin_lvl_r[1];
  assign pll_ok   = pin_lvl_r[2];
  assign pwr_up   = pin_lvl_r[3];
  assign pmm_stop = pin_lvl_r[4];
  // strap is read straight from the third stage, without the agreement check, so reset can use it
  assign programming_mode_q   = pin_q3[5];

  logic osc_prev_r;
  logic osc_edge;

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      osc_prev_r <= 1'b0;
    end else begin
      osc_prev_r <= osc_lvl;
    end
  end

  assign osc_edge = osc_lvl && !osc_prev_r;

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave

  logic                  awready_r;
  logic                  wready_r;
  logic                  bvalid_r;
  logic [1:0]            bresp_r;
  logic [AXI_ADDR_W-1:0] awaddr_r;
  logic [7:0]            wbyte_r;
  logic                  wlane_r;
  logic                  arready_r;
  logic                  rvalid_r;
  logic [AXI_DATA_W-1:0] rdata_r;
  logic [1:0]            rresp_r;
  logic                  wr_go;
  logic                  wr_hit;
  logic                  wr_ctl;
  logic                  wr_fast;
  logic                  wr_slow;
  logic                  wr_aux;

  assign wr_go   = !awready_r && !wready_r && !bvalid_r;
  assign wr_hit  = awaddr_r == CTL_OFS || awaddr_r == FAST_OFS ||
                   awaddr_r == SLOW_OFS || awaddr_r == AUX_OFS ||
                   awaddr_r == STAT_OFS;
  assign wr_ctl  = wr_go && wlane_r && awaddr_r == CTL_OFS;
  assign wr_fast = wr_go && wlane_r && awaddr_r == FAST_OFS;
  assign wr_slow = wr_go && wlane_r && awaddr_r == SLOW_OFS;
  assign wr_aux  = wr_go && wlane_r && awaddr_r == AUX_OFS;

  // address and data are taken independently; the response follows both
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      awaddr_r  <= '0;
      wbyte_r   <= '0;
      wlane_r   <= 1'b0;
    end else begin
      if (awready_r && S_AXI_AWVALID) begin
        awready_r <= 1'b0;
        awaddr_r  <= S_AXI_AWADDR;
      end
      if (wready_r && S_AXI_WVALID) begin
        wready_r <= 1'b0;
        wbyte_r  <= S_AXI_WDATA[7:0];
        wlane_r  <= S_AXI_WSTRB[0];
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_r && S_AXI_BREADY) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  clock_reset_control_t  ctl_r;
  fast_clock_prescaler_t fast_r;
  logic [7:0]            slow_r;
  aux_clock_prescaler_t  aux_r;

  // source select and pll power-down, each guarded by the other
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      ctl_r.slow_source_select <= CTL_RST[SLOW_SRC_BIT];
      ctl_r.fast_source_select <= CTL_RST[FAST_SEL_BIT];
      ctl_r.pll_power_down     <= CTL_RST[PWD_BIT];
      ctl_r.aux1_enable        <= 1'b0;
      ctl_r.aux2_enable        <= 1'b0;
    end else if (wr_ctl) begin
      ctl_r.slow_source_select <= wbyte_r[SLOW_SRC_BIT];
      ctl_r.aux1_enable        <= wbyte_r[3];
      ctl_r.aux2_enable        <= wbyte_r[4];
      if (wbyte_r[FAST_SEL_BIT]) begin
        ctl_r.fast_source_select <= 1'b1;
      end else if (!ctl_r.pll_power_down && pll_ok) begin
        ctl_r.fast_source_select <= 1'b0;
      end
      if (!wbyte_r[PWD_BIT]) begin
        ctl_r.pll_power_down <= 1'b0;
      end else if (ctl_r.fast_source_select) begin
        ctl_r.pll_power_down <= 1'b1;
      end
    end
  end

  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      ctl_r.por_flag <= CTL_RST[POR_BIT];
    end else if (pwr_up) begin
      ctl_r.por_flag <= 1'b1;
    end else if (wr_ctl && !wbyte_r[POR_BIT]) begin
      ctl_r.por_flag <= 1'b0;
    end
  end

  assign ctl_r.reserved = 2'h0;

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      fast_r <= programming_mode_q ? PROGRAMMING_MODE_FAST_INIT : FAST_RST;
    end else if (wr_fast) begin
      fast_r <= {1'b0, wbyte_r[6:0]};
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      slow_r <= SLOW_RST;
    end else if (wr_slow) begin
      slow_r <= wbyte_r;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      aux_r <= AUX_RST;
    end else if (wr_aux) begin
      aux_r <= wbyte_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel

  logic [7:0] rd_byte;
  logic       rd_hit;

  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    case (S_AXI_ARADDR)
      CTL_OFS:    rd_byte = ctl_r;
      FAST_OFS:   rd_byte = fast_r;
      SLOW_OFS:   rd_byte = slow_r;
      AUX_OFS:    rd_byte = aux_r;
      STAT_OFS:   rd_byte = {5'h00, programming_mode_q, pll_ok, main_ok};
      default:    rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= RESP_OKAY;
    end else if (arready_r && S_AXI_ARVALID) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= {24'h000000, rd_byte};
      rresp_r   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && S_AXI_RREADY) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  assign S_AXI_AWREADY = awready_r;
  assign S_AXI_WREADY  = wready_r;
  assign S_AXI_BVALID  = bvalid_r;
  assign S_AXI_BRESP   = bresp_r;
  assign S_AXI_ARREADY = arready_r;
  assign S_AXI_RVALID  = rvalid_r;
  assign S_AXI_RDATA   = rdata_r;
  assign S_AXI_RRESP   = rresp_r;

  ////////////////////////////////////////////////////////////////////////////
  // prescalers

  logic fast_src_tick;
  logic slow_presc_tick;
  logic aux1_run;
  logic aux2_run;

  assign fast_src_tick = ctl_r.fast_source_select ? MAIN_TICK : PLL_TICK;
  assign aux1_run      = ctl_r.aux1_enable && main_ok;
  assign aux2_run      = ctl_r.aux2_enable && main_ok;

  tick_divider #(.W(FAST_DIV_W)) u_sys_div (
    .clk      (CLK_SYS),
    .rst_n    (RST_N),
    .run      (1'b1),
    .tick_in  (fast_src_tick),
    .div      (fast_r.fast_divisor),
    .tick_out (SYS_CLK_EN)
  );

  // doubling the divisor plus one gives 2 * (div + 1)
  tick_divider #(.W(SLOW_DIV_W + 1)) u_slow_div (
    .clk      (CLK_SYS),
    .rst_n    (RST_N),
    .run      (!ctl_r.slow_source_select),
    .tick_in  (MAIN_TICK),
    .div      ({slow_r, 1'b1}),
    .tick_out (slow_presc_tick)
  );

  tick_divider #(.W(AUX_DIV_W)) u_aux1_div (
    .clk      (CLK_SYS),
    .rst_n    (RST_N),
    .run      (aux1_run),
    .tick_in  (MAIN_TICK),
    .div      (aux_r.aux1_divisor),
    .tick_out (AUX1_CLK_EN)
  );

  tick_divider #(.W(AUX_DIV_W)) u_aux2_div (
    .clk      (CLK_SYS),
    .rst_n    (RST_N),
    .run      (aux2_run),
    .tick_in  (MAIN_TICK),
    .div      (aux_r.aux2_divisor),
    .tick_out (AUX2_CLK_EN)
  );

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      SLOW_CLK_EN <= 1'b0;
    end else if (ctl_r.slow_source_select) begin
      SLOW_CLK_EN <= osc_edge;
    end else begin
      SLOW_CLK_EN <= slow_presc_tick;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      PLL_STOP <= 1'b1;
      PLL_MULT <= MODE_X4;
    end else begin
      PLL_STOP <= ctl_r.pll_power_down || pmm_stop;
      PLL_MULT <= fast_r.pll_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  pwd_stop_a: assert property (ctl_r.pll_power_down |=> PLL_STOP)
    else $error("pll stop low while powered down");
  fast_source_select_pwd_a: assert property (
    wr_ctl && !wbyte_r[FAST_SEL_BIT] && ctl_r.pll_power_down
    |=> ctl_r.fast_source_select)
    else $error("pll selected while powered down");
  fast_source_select_stable_a: assert property (
    wr_ctl && !wbyte_r[FAST_SEL_BIT] && !pll_ok
    |=> ctl_r.fast_source_select == $past(ctl_r.fast_source_select))
    else $error("fast select cleared before pll stable");
  pwd_guard_a: assert property (
    wr_ctl && !ctl_r.fast_source_select |=> !ctl_r.pll_power_down)
    else $error("pll powered down while selected");
  reset_vals_a: assert property (disable iff (1'b0)
    $rose(RST_N) |-> ctl_r.pll_power_down && ctl_r.fast_source_select && PLL_STOP)
    else $error("control register reset value wrong");
  por_keep_a: assert property (
    wr_ctl && wbyte_r[POR_BIT] && !pwr_up |=> $stable(ctl_r.por_flag))
    else $error("writing one changed por flag");
  aux1_stop_a: assert property (!aux1_run |=> !AUX1_CLK_EN)
    else $error("aux clock 1 ran while stopped");
  aux2_stop_a: assert property (!aux2_run |=> !AUX2_CLK_EN)
    else $error("aux clock 2 ran while stopped");
  slow_osc_a: assert property (
    ctl_r.slow_source_select && osc_edge |=> SLOW_CLK_EN)
    else $error("slow clock missed oscillator edge");

endmodule

// ### common/clk_ctrl_pkg.sv
// shared constants and register layouts for the clock selection block
package clk_ctrl_pkg;

  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;

  // register byte addresses
  localparam logic [AXI_ADDR_W-1:0] CTL_OFS    = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] FAST_OFS   = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] SLOW_OFS   = 8'h08;
  localparam logic [AXI_ADDR_W-1:0] AUX_OFS    = 8'h0c;
  localparam logic [AXI_ADDR_W-1:0] STAT_OFS   = 8'h10;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // field positions within the control register
  localparam int SLOW_SRC_BIT = 0;
  localparam int FAST_SEL_BIT = 1;
  localparam int PWD_BIT      = 2;
  localparam int POR_BIT      = 5;

  localparam int FAST_DIV_W = 4;
  localparam int SLOW_DIV_W = 8;
  localparam int AUX_DIV_W  = 4;

  typedef struct packed {
    logic [1:0] reserved;
    logic       por_flag;
    logic       aux2_enable;
    logic       aux1_enable;
    logic       pll_power_down;
    logic       fast_source_select;
    logic       slow_source_select;
  } clock_reset_control_t;

  typedef struct packed {
    logic                  reserved;
    logic [2:0]            pll_mode;
    logic [FAST_DIV_W-1:0] fast_divisor;
  } fast_clock_prescaler_t;

  typedef struct packed {
    logic [AUX_DIV_W-1:0] aux2_divisor;
    logic [AUX_DIV_W-1:0] aux1_divisor;
  } aux_clock_prescaler_t;

  localparam logic [7:0] CTL_RST    = 8'h26;
  localparam logic [7:0] FAST_RST   = 8'h4f;
  localparam logic [7:0] SLOW_RST   = 8'hb6;
  localparam logic [7:0] AUX_RST    = 8'hff;

  localparam logic [2:0] MODE_X3 = 3'h3;
  localparam logic [2:0] MODE_X4 = 3'h4;
  localparam logic [2:0] MODE_X5 = 3'h5;

endpackage

// ### logic/tick_divider.sv
// enable-pulse divider: one output pulse per (div + 1) input ticks
`timescale 1ns/100ps
module tick_divider #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // control
  input  wire logic         run,
  input  wire logic         tick_in,
  input  wire logic [W-1:0] div,
  // result
  output logic              tick_out
);

  logic [W-1:0] cnt_r;

  // counter restarts when stopped; >= copes with a divisor made smaller
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      cnt_r <= '0;
    end else if (tick_in) begin
      if (cnt_r >= div) begin
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= run && tick_in && (cnt_r >= div);
    end
  end

endmodule

// ### bench/clock_select_prescalers_tb_top.sv
// self-checking bench for the clock selection and prescaler block
`timescale 1ns/100ps
module clock_select_prescalers_tb_top;
  import clk_ctrl_pkg::*;
  localparam logic [7:0] PROGRAMMING_MODE_INIT = 8'h3a;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        main_tick = 0, pll_tick = 1, osc = 0, main_ok = 1, pll_ok = 0;
  logic        pwr_up = 0, pmm_stop = 0, programming_mode = 0, osc_run = 0;
  logic        sys_en, slow_en, aux1_en, aux2_en, pll_stop;
  logic [2:0]  pll_mult;
  logic [3:0]  ens;
  int          n_mismatch = 0, n_checks = 0, cyc = 0;
  int          last[4], prev[4], npls[4];

  clock_select_prescalers #(.PROGRAMMING_MODE_FAST_INIT(PROGRAMMING_MODE_INIT)) uut (
    .CLK_SYS(clk), .RST_N(rst_n),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWPROT(3'h0), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .MAIN_TICK(main_tick), .PLL_TICK(pll_tick),
    .OSC32K_IN(osc), .MAIN_STABLE(main_ok), .PLL_STABLE(pll_ok),
    .POWER_UP_DET(pwr_up), .PMM_PLL_STOP(pmm_stop), .PROGRAMMING_MODE(programming_mode),
    .SYS_CLK_EN(sys_en), .SLOW_CLK_EN(slow_en), .AUX1_CLK_EN(aux1_en),
    .AUX2_CLK_EN(aux2_en), .PLL_STOP(pll_stop), .PLL_MULT(pll_mult)
  );

  assign ens = {aux2_en, aux1_en, slow_en, sys_en};
  always #12.5 clk = ~clk;

  // main tick every second cycle, oscillator period of 40 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    main_tick <= ~main_tick;
    if (osc_run && cyc % 20 == 0) osc <= ~osc;
    for (int i = 0; i < 4; i++) begin
      if (ens[i] === 1'b1) begin
        prev[i] = last[i];
        last[i] = cyc;
        npls[i]++;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_checks++;
    if (got !== ex) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw, w;
    int t;
    aw = 0;
    w = 0;
    t = 0;
    awvalid <= 1; awaddr <= a; wvalid <= 1; wdata <= {24'h0, d}; bready <= 1;
    while (!(aw && w) && t < 50) begin
      @(posedge clk);
      t++;
      if (awready === 1'b1 && !aw) begin aw = 1; awvalid <= 0; end
      if (wready === 1'b1 && !w) begin w = 1; wvalid <= 0; end
    end
    while (bvalid !== 1'b1 && t < 100) begin @(posedge clk); t++; end
    if (bvalid !== 1'b1) n_mismatch++;
    bready <= 0;
    chk("write response", er, bresp);
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
    int t;
    t = 0;
    arvalid <= 1; araddr <= a; rready <= 1;
    do begin @(posedge clk); t++; end while (arready !== 1'b1 && t < 50);
    arvalid <= 0;
    do begin @(posedge clk); t++; end while (rvalid !== 1'b1 && t < 100);
    if (rvalid !== 1'b1) n_mismatch++;
    rready <= 0;
    chk("read data", ex, rdata);
    chk("read response", er, rresp);
    @(posedge clk);
  endtask

  // spacing of the last two pulses once the setting has settled
  task automatic per(input int i, input int ex);
    repeat (3 * ex + 8) @(posedge clk);
    chk("enable period", ex, last[i] - prev[i]);
  endtask

  task automatic quiet(input int i);
    int n;
    n = npls[i];
    repeat (40) @(posedge clk);
    chk("stopped enable", n, npls[i]);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(CTL_OFS, 32'h26, RESP_OKAY);
    rd(FAST_OFS, 32'h4f, RESP_OKAY);
    rd(SLOW_OFS, 32'hb6, RESP_OKAY);
    rd(AUX_OFS, 32'hff, RESP_OKAY);
    chk("pll stop", 1, pll_stop);
    chk("pll mult", MODE_X4, pll_mult);
  endtask

  task automatic t_ctrl;
    wr(CTL_OFS, 8'h24, RESP_OKAY);
    rd(CTL_OFS, 32'h26, RESP_OKAY);
    wr(CTL_OFS, 8'h22, RESP_OKAY);
    repeat (6) @(posedge clk);
    chk("pll stop", 0, pll_stop);
    pmm_stop <= 1;
    repeat (8) @(posedge clk);
    chk("pll stop", 1, pll_stop);
    pmm_stop <= 0;
    wr(CTL_OFS, 8'h20, RESP_OKAY);
    rd(CTL_OFS, 32'h22, RESP_OKAY);
    pll_ok <= 1;
    repeat (8) @(posedge clk);
    wr(CTL_OFS, 8'h20, RESP_OKAY);
    rd(CTL_OFS, 32'h20, RESP_OKAY);
    per(0, 16);
    wr(CTL_OFS, 8'h24, RESP_OKAY);
    rd(CTL_OFS, 32'h20, RESP_OKAY);
    wr(CTL_OFS, 8'h22, RESP_OKAY);
    per(0, 32);
  endtask

  task automatic t_fast;
    logic [2:0] m[3] = '{MODE_X3, MODE_X4, MODE_X5};
    for (int i = 0; i < 3; i++) begin
      wr(FAST_OFS, {1'b0, m[i], 4'h3}, RESP_OKAY);
      repeat (3) @(posedge clk);
      chk("pll mult", m[i], pll_mult);
    end
    per(0, 8);
    wr(FAST_OFS, 8'h40, RESP_OKAY);
    per(0, 2);
  endtask

  task automatic t_slow;
    wr(SLOW_OFS, 8'h02, RESP_OKAY);
    per(1, 12);
    osc_run <= 1;
    wr(CTL_OFS, 8'h23, RESP_OKAY);
    per(1, 40);
    wr(CTL_OFS, 8'h22, RESP_OKAY);
    osc_run <= 0;
  endtask

  task automatic t_aux;
    wr(AUX_OFS, 8'h52, RESP_OKAY);
    wr(CTL_OFS, 8'h3a, RESP_OKAY);
    per(2, 6);
    per(3, 12);
    main_ok <= 0;
    repeat (8) @(posedge clk);
    quiet(2);
    quiet(3);
    main_ok <= 1;
    wr(CTL_OFS, 8'h2a, RESP_OKAY);
    per(2, 6);
    quiet(3);
  endtask

  task automatic t_por;
    wr(CTL_OFS, 8'h02, RESP_OKAY);
    rd(CTL_OFS, 32'h02, RESP_OKAY);
    wr(CTL_OFS, 8'h22, RESP_OKAY);
    rd(CTL_OFS, 32'h02, RESP_OKAY);
    pwr_up <= 1;
    repeat (8) @(posedge clk);
    pwr_up <= 0;
    repeat (8) @(posedge clk);
    rd(CTL_OFS, 32'h22, RESP_OKAY);
    wr(8'h20, 8'h00, RESP_SLVERR);
    rd(8'h20, 32'h0, RESP_SLVERR);
  endtask

  task automatic t_programming_mode;
    programming_mode <= 1;
    repeat (4) @(posedge clk);
    do_reset();
    rd(FAST_OFS, {24'h0, PROGRAMMING_MODE_INIT}, RESP_OKAY);
    rd(STAT_OFS, 32'h07, RESP_OKAY);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    test_done();
  end

  initial begin
    do_reset();
    t_reset();
    t_ctrl();
    t_fast();
    t_slow();
    t_aux();
    t_por();
    t_programming_mode();
    test_done();
  end
endmodule
